/* File: core/rate_divider.sv */
//
// Purpose: preloaded rate counter with a chain of divide-by-two taps
// Assumes: preload values are at least 1 and stable while running
// Notes:   taps[0] is the family's top rate, each further tap halves it
//
`timescale 1ns/10ps
module rate_divider
  import serial_clk_pkg::*;
#(
  parameter int TAPS = NUM_TAPS,
  parameter int W = CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // family selection
  input wire logic familyB,
  input wire logic [W-1:0] preloadA,
  input wire logic [W-1:0] preloadB,
  // divided outputs
  output logic [TAPS-1:0] taps
);

  logic [W-1:0] cnt_ff;
  logic [TAPS-1:0] div_ff;
  logic [W-1:0] nxt_load;

  assign nxt_load = familyB ? preloadB : preloadA;
  assign taps = div_ff;

  // ************************************************************
  // preload counter
  // ************************************************************
  // reload at terminal count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (cnt_ff <= W'(1)) begin
        cnt_ff <= nxt_load;
      end else begin
        cnt_ff <= cnt_ff - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= '0;
    end else if (ce && cnt_ff <= W'(1)) begin
      div_ff <= div_ff + TAPS'(1);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_family_reload: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && cnt_ff <= W'(1) |=> cnt_ff == $past(nxt_load))
    else $error("counter did not reload the selected family preload");

endmodule

/* File: core/serial_baud_clock_routing.sv */
//
// Purpose: bit-clock generator plus clock and handshake routing for the
//          serial controller and its line connector
// Assumes: controller status and RTS are on clk; connector lines are not
// Notes:   connector clocks are oversampled, so their edges jitter by
//          one clk period and they must stay well below clk/4
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
module serial_baud_clock_routing
  import serial_clk_pkg::*;
#(
  parameter int TAPS = NUM_TAPS,
  parameter logic [CNT_W-1:0] PRELOAD_FAM_A = CNT_W'(PRELOAD_A),
  parameter logic [CNT_W-1:0] PRELOAD_FAM_B = CNT_W'(PRELOAD_B)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [DATA_W-1:0] rdata,
  // serial controller side
  input wire logic ctrlRts_b,
  input wire logic receiver_has_char,
  input wire logic transmitter_can_accept,
  input wire logic transmitter_drained,
  output logic ctrlTxClk,
  output logic ctrlRxClk,
  output logic ctrlDsr_b,
  output logic ctrlCts_b,
  output logic serial_irq_n,
  // connector side
  input wire logic sharedLine,
  input wire logic terminal_tx_clock,
  input wire logic offboardRts_b,
  output logic offboardCts_b,
  output logic offboardCtsOe_b,
  output logic rxClkPin,
  output logic rxClkPinOe_b,
  // status
  output logic syncAllowed
);

  localparam int NPIN = 3;
  localparam int PIN_LINE = 0;
  localparam int PIN_TERM = 1;
  localparam int PIN_RTS = 2;

  logic [DATA_W-1:0] cfg_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [NPIN-1:0] pinAsync;
  logic [NPIN-1:0] syncMeta_ff;
  logic [NPIN-1:0] syncPin_ff;
  logic [TAPS-1:0] taps;
  logic genClk_ff;
  logic syncOk_ff;
  logic extPrev_ff;
  logic extSeen_ff;
  logic txClk_ff;
  logic rxClk_ff;
  logic dsr_b_ff;
  logic cts_b_ff;
  logic ctsOut_b_ff;
  logic ctsOe_b_ff;
  logic rxPin_ff;
  logic rxPinOe_b_ff;
  logic irqN_ff;

  logic cfgFamB;
  logic [2:0] cfgRate;
  logic cfgTxExt;
  logic cfgRxExt;
  logic cfgLineClk;
  cts_src_t cfgCts;
  logic cfgRtsOut;
  logic cfgRxDrive;
  logic cfgIrqRx;
  irq_tx_t cfgIrqTx;
  logic txExtEff;
  logic nxt_txClk;
  logic nxt_rxClk;
  logic nxt_cts_b;
  logic nxt_irqActive;
  logic extSel;
  logic extEdge;
  logic cfgWr;
  logic statWr;
  logic [2:0] wrRate;
  logic [1:0] wrIrqTx;
  logic [DATA_W-1:0] nxt_cfg;
  logic [DATA_W-1:0] nxt_rdata;

  // ************************************************************
  // configuration fields
  // ************************************************************
  assign cfgFamB = cfg_ff[CFG_PRELOAD];
  assign cfgRate = cfg_ff[CFG_RATE_LSB +: 3];
  assign cfgTxExt = cfg_ff[CFG_TX_EXT];
  assign cfgRxExt = cfg_ff[CFG_RX_EXT];
  assign cfgLineClk = cfg_ff[CFG_LINE_CLK];
  assign cfgCts = cts_src_t'(cfg_ff[CFG_CTS_LSB +: 2]);
  assign cfgRtsOut = cfg_ff[CFG_RTS_OUT];
  assign cfgRxDrive = cfg_ff[CFG_RXC_DRIVE];
  assign cfgIrqRx = cfg_ff[CFG_IRQ_RX];
  assign cfgIrqTx = irq_tx_t'(cfg_ff[CFG_IRQ_TX_LSB +: 2]);

  assign cfgWr = we && addr == CFG_ADDR;
  assign statWr = we && addr == STAT_ADDR;
  assign wrRate = wdata[CFG_RATE_LSB +: 3];
  assign wrIrqTx = wdata[CFG_IRQ_TX_LSB +: 2];

  // ************************************************************
  // register port
  // ************************************************************
  // out-of-range rate and two transmit irq sources are refused fieldwise
  always_comb begin
    nxt_cfg = wdata;
    if (wrRate > LAST_TAP) begin
      nxt_cfg[CFG_RATE_LSB +: 3] = cfgRate;
    end
    if (wrIrqTx == 2'h3) begin
      nxt_cfg[CFG_IRQ_TX_LSB +: 2] = cfg_ff[CFG_IRQ_TX_LSB +: 2];
    end
  end

  // software is expected to change this only while idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= CFG_RESET;
    end else if (ce && cfgWr) begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (addr == CFG_ADDR) begin
      nxt_rdata = cfg_ff;
    end else if (addr == STAT_ADDR) begin
      nxt_rdata[STAT_SYNC_OK] = syncOk_ff;
      nxt_rdata[STAT_GEN] = genClk_ff;
      nxt_rdata[STAT_EXT_SEEN] = extSeen_ff;
      nxt_rdata[STAT_RATE_LSB +: 3] = cfgRate;
    end
  end

  // read data stands for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= re ? nxt_rdata : '0;
    end
  end

  // ************************************************************
  // connector input synchronisers
  // ************************************************************
  assign pinAsync[PIN_LINE] = sharedLine;
  assign pinAsync[PIN_TERM] = terminal_tx_clock;
  assign pinAsync[PIN_RTS] = offboardRts_b;

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        syncMeta_ff[i] <= 1'b1;
        syncPin_ff[i] <= 1'b1;
      end else if (ce) begin
        syncMeta_ff[i] <= pinAsync[i];
        syncPin_ff[i] <= syncMeta_ff[i];
      end
    end
  end

  // ************************************************************
  // rate generator
  // ************************************************************
  // family preload
  rate_divider #(
    .TAPS(TAPS),
    .W(CNT_W)
  ) u_div (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .familyB(cfgFamB),
    .preloadA(PRELOAD_FAM_A),
    .preloadB(PRELOAD_FAM_B),
    .taps(taps)
  );

  // this is the controller's bit clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      genClk_ff <= 1'b0;
    end else if (ce) begin
      genClk_ff <= taps[cfgRate];
    end
  end

  // sync only at the slower taps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncOk_ff <= 1'b0;
    end else if (ce) begin
      syncOk_ff <= cfgRate >= (cfgFamB ? SYNC_MIN_TAP_B : SYNC_MIN_TAP);
    end
  end

  // ************************************************************
  // clock routing
  // ************************************************************
  // line carries a clock only in clock use
  assign txExtEff = cfgTxExt && cfgLineClk;
  assign nxt_txClk = txExtEff ? syncPin_ff[PIN_LINE] : genClk_ff;
  assign nxt_rxClk = cfgRxExt ? syncPin_ff[PIN_TERM] : genClk_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txClk_ff <= 1'b0;
      rxClk_ff <= 1'b0;
    end else if (ce) begin
      txClk_ff <= nxt_txClk;
      rxClk_ff <= nxt_rxClk;
    end
  end

  // receive clock out to the connector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxPin_ff <= 1'b0;
      rxPinOe_b_ff <= 1'b1;
    end else if (ce) begin
      rxPin_ff <= nxt_rxClk;
      rxPinOe_b_ff <= !cfgRxDrive;
    end
  end

  // external clock activity, sticky; set wins over a clear
  assign extSel = txExtEff ? syncPin_ff[PIN_LINE] : syncPin_ff[PIN_TERM];
  assign extEdge = extSel != extPrev_ff && (txExtEff || cfgRxExt);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extPrev_ff <= 1'b1;
      extSeen_ff <= 1'b0;
    end else if (ce) begin
      extPrev_ff <= extSel;
      if (extEdge) begin
        extSeen_ff <= 1'b1;
      end else if (statWr && wdata[STAT_EXT_SEEN]) begin
        extSeen_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // handshake routing
  // ************************************************************
  always_comb begin
    unique case (cfgCts)
      CTS_OFFBOARD: nxt_cts_b = syncPin_ff[PIN_RTS];
      CTS_LOOP: nxt_cts_b = ctrlRts_b;
      CTS_GROUND: nxt_cts_b = 1'b0;
      default: nxt_cts_b = 1'b1;
    endcase
  end

  // DSR held inactive while the line is a clock
  // CTS source and RTS to off-board CTS
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dsr_b_ff <= 1'b1;
      cts_b_ff <= 1'b1;
      ctsOut_b_ff <= 1'b1;
      ctsOe_b_ff <= 1'b1;
    end else if (ce) begin
      dsr_b_ff <= cfgLineClk ? 1'b1 : syncPin_ff[PIN_LINE];
      cts_b_ff <= nxt_cts_b;
      ctsOut_b_ff <= ctrlRts_b;
      ctsOe_b_ff <= !cfgRtsOut;
    end
  end

  // ************************************************************
  // interrupt source
  // ************************************************************
  // receive plus one transmit source
  always_comb begin
    nxt_irqActive = cfgIrqRx && receiver_has_char;
    unique case (cfgIrqTx)
      IRQ_TX_NONE: nxt_irqActive = nxt_irqActive;
      IRQ_TX_READY: nxt_irqActive = nxt_irqActive || transmitter_can_accept;
      IRQ_TX_EMPTY: nxt_irqActive = nxt_irqActive || transmitter_drained;
      default: nxt_irqActive = nxt_irqActive;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqN_ff <= 1'b1;
    end else if (ce) begin
      irqN_ff <= !nxt_irqActive;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rdata = rdata_ff;
  assign ctrlTxClk = txClk_ff;
  assign ctrlRxClk = rxClk_ff;
  assign ctrlDsr_b = dsr_b_ff;
  assign ctrlCts_b = cts_b_ff;
  assign serial_irq_n = irqN_ff;
  assign offboardCts_b = ctsOut_b_ff;
  assign offboardCtsOe_b = ctsOe_b_ff;
  assign rxClkPin = rxPin_ff;
  assign rxClkPinOe_b = rxPinOe_b_ff;
  assign syncAllowed = syncOk_ff;

  // ************************************************************
  // checks
  // ************************************************************
  a_gen_tap_select: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce ##1 ce |-> txClk_ff == $past(genClk_ff) || txExtEff || $past(txExtEff))
    else $error("transmit clock does not follow the generator tap");

  a_sync_rate_limit: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && cfgRate < (cfgFamB ? SYNC_MIN_TAP_B : SYNC_MIN_TAP) |=> !syncAllowed)
    else $error("sync allowed at a fast tap");

  a_tx_clock_source: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && txExtEff |=> ctrlTxClk == $past(syncPin_ff[PIN_LINE]))
    else $error("transmit clock not taken from the connector line");

  a_rx_clock_source: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce |=> ctrlRxClk == ($past(cfgRxExt) ? $past(syncPin_ff[PIN_TERM]) : $past(genClk_ff)))
    else $error("receive clock from the wrong source");

  a_line_exclusive: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && cfgLineClk |=> ctrlDsr_b)
    else $error("DSR asserted while the shared line is a clock");

  a_cts_ground: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && cfgCts == CTS_GROUND ##1 ce && cfgCts == CTS_GROUND |-> !ctrlCts_b)
    else $error("grounded CTS not asserted");

  a_rxclk_pin_drive: assert property (
    @(posedge clk) disable iff (!rst_b)
    !rxClkPinOe_b |-> rxClkPin == ctrlRxClk)
    else $error("driven receive clock differs from controller clock");

  a_irq_tx_source: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && !cfgIrqRx && cfgIrqTx == IRQ_TX_EMPTY
    |=> serial_irq_n == !$past(transmitter_drained))
    else $error("interrupt does not follow transmitter drained");

  a_reset_defaults: assert property (
    @(posedge clk) $rose(rst_b) |-> cfg_ff == CFG_RESET && !cfgFamB)
    else $error("configuration not at defaults after reset");

  a_read_one_cycle: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce && !re |=> rdata == '0)
    else $error("read data present without a read strobe");

endmodule

/* File: core/serial_clk_pkg.sv */
//
// Purpose: constants and types shared by the serial clock routing block
// Assumes: block clock is 10 MHz and also serves as the rate oscillator
// Notes:   preload counts are rounded down, so the rates run slightly fast
//
package serial_clk_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int TOP_A_HZ = 307_200;
  localparam int TOP_B_HZ = 460_800;
  // the counter half-period gives the top rate of each family
  localparam int PRELOAD_A = CLK_HZ / (2 * TOP_A_HZ);
  localparam int PRELOAD_B = CLK_HZ / (2 * TOP_B_HZ);
  localparam int NUM_TAPS = 7;
  localparam int CNT_W = 8;
  localparam logic [2:0] SYNC_MIN_TAP = 3'h3;
  // faster family: sync only from one tap further down
  localparam logic [2:0] SYNC_MIN_TAP_B = 3'h4;
  localparam logic [2:0] LAST_TAP = 3'h6;

  // ************************************************************
  // register port
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;

  localparam int CFG_PRELOAD = 0;
  localparam int CFG_RATE_LSB = 1;
  localparam int CFG_TX_EXT = 4;
  localparam int CFG_RX_EXT = 5;
  localparam int CFG_LINE_CLK = 6;
  localparam int CFG_CTS_LSB = 7;
  localparam int CFG_RTS_OUT = 9;
  localparam int CFG_RXC_DRIVE = 10;
  localparam int CFG_IRQ_RX = 11;
  localparam int CFG_IRQ_TX_LSB = 12;
  // family A, 19.2 kHz tap, generator clocks, RTS to off-board CTS
  localparam logic [15:0] CFG_RESET = 16'h0208;

  localparam int STAT_SYNC_OK = 0;
  localparam int STAT_GEN = 1;
  localparam int STAT_EXT_SEEN = 2;
  localparam int STAT_RATE_LSB = 4;

  typedef enum logic [1:0] {CTS_OFFBOARD, CTS_LOOP, CTS_GROUND} cts_src_t;
  typedef enum logic [1:0] {IRQ_TX_NONE, IRQ_TX_READY, IRQ_TX_EMPTY} irq_tx_t;

endpackage

/* File: tb/serial_baud_clock_routing_tb.sv */
//
// Purpose: self-checking bench for the serial clock routing block
// Assumes: preload parameters left at their package defaults
// Notes:   config is only changed between link frames
//
`timescale 1ns/10ps
module serial_baud_clock_routing_tb
  import serial_clk_pkg::*;
;
  logic clk, rst_b, ce, we, re;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, rdv, cfg;
  logic ctrlRts_b, rxChar, txAccept, txDrained, offboardRts_b;
  logic ctrlTxClk, ctrlRxClk, ctrlDsr_b, ctrlCts_b, serial_irq_n;
  logic sharedLine, termClk, offboardCts_b, offboardCtsOe_b;
  logic rxClkPin, rxClkPinOe_b, syncAllowed, frameOn, lineIsClk, dtr_b;
  logic [5:0] hist;
  logic hold;
  logic [31:0] r;
  int mismatches, n_compared, hp, tap, fam, k;

  serial_baud_clock_routing dut_u (
    .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .ctrlRts_b(ctrlRts_b),
    .receiver_has_char(rxChar), .transmitter_can_accept(txAccept),
    .transmitter_drained(txDrained), .ctrlTxClk(ctrlTxClk),
    .ctrlRxClk(ctrlRxClk), .ctrlDsr_b(ctrlDsr_b), .ctrlCts_b(ctrlCts_b),
    .serial_irq_n(serial_irq_n), .sharedLine(sharedLine),
    .terminal_tx_clock(termClk), .offboardRts_b(offboardRts_b),
    .offboardCts_b(offboardCts_b), .offboardCtsOe_b(offboardCtsOe_b),
    .rxClkPin(rxClkPin), .rxClkPinOe_b(rxClkPinOe_b),
    .syncAllowed(syncAllowed));

  serial_line_model line_u (
    .frameOn(frameOn), .lineIsClk(lineIsClk), .dtr_b(dtr_b),
    .sharedLine(sharedLine), .terminal_tx_clock(termClk));

  // ************************************************************
  // clock, history and helpers
  // ************************************************************
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // pins reach the outputs two edges after capture
  always @(posedge clk) hist <= {hist[3:0], sharedLine, termClk};

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one full half period of the transmit clock, bounded
  task automatic halfp(output int n);
    logic v;
    v = ctrlTxClk;
    n = 0;
    for (int i = 0; i < 3000 && ctrlTxClk === v; i++) cyc(1);
    v = ctrlTxClk;
    for (int i = 0; i < 3000 && ctrlTxClk === v; i++) begin
      cyc(1);
      n++;
    end
  endtask

  function automatic int expHalf(input int f, input int t);
    return (f == 1 ? PRELOAD_B : PRELOAD_A) * (2 ** t);
  endfunction

  function automatic logic expIrq(input logic [15:0] c, input logic [2:0] s);
    return !((c[11] & s[0]) | (c[13:12] == 2'h1 & s[1]) | (c[13:12] == 2'h2 & s[2]));
  endfunction

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rst_b, we, re, rxChar, txAccept, txDrained, frameOn, lineIsClk} = 8'h00;
    {ce, ctrlRts_b, offboardRts_b, dtr_b} = 4'hF;
    addr = 4'h0;
    wdata = 16'h0000;
    r = $urandom(32'h275399a1);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(CFG_ADDR, rdv);
    chk(rdv, CFG_RESET);
    rd(STAT_ADDR, rdv);
    chk(rdv & 16'h0071, 16'h0041);
    rd(4'h8, rdv);
    chk(rdv, 16'h0000);
    // every family and tap, each family's slowest tap reached last
    for (fam = 0; fam < 2; fam++) begin
      for (tap = 0; tap < 7; tap++) begin
        wr(CFG_ADDR, 16'h0200 | 16'(fam) | 16'(tap << 1));
        halfp(hp);
        halfp(hp);
        chk(16'(hp), 16'(expHalf(fam, tap)));
        chk(16'(syncAllowed), 16'(tap >= (fam ? SYNC_MIN_TAP_B : SYNC_MIN_TAP)));
      end
    end
    // refused rate and irq codes keep their old fields
    wr(CFG_ADDR, 16'h020E);
    rd(CFG_ADDR, rdv);
    chk(rdv, 16'h020C);
    wr(CFG_ADDR, 16'h320A);
    wr(4'h8, 16'h3FFF);
    rd(CFG_ADDR, rdv);
    chk(rdv, 16'h020A);
    // random handshake and interrupt routing, static per step
    for (k = 0; k < 12; k++) begin
      r = $urandom;
      cfg = {2'b00, 2'((k / 3) % 3), r[2:0], 2'(k % 3), 7'h08};
      @(posedge clk);
      ctrlRts_b <= r[3];
      rxChar <= r[4];
      txAccept <= r[5];
      txDrained <= r[6];
      offboardRts_b <= r[7];
      dtr_b <= r[8];
      wr(CFG_ADDR, cfg);
      cyc(5);
      chk(ctrlCts_b, k % 3 == 0 ? r[7] : (k % 3 == 1 ? r[3] : 1'b0));
      chk(offboardCtsOe_b, !r[0]);
      if (r[0]) begin
        chk(offboardCts_b, r[3]);
      end
      chk(rxClkPinOe_b, !r[1]);
      chk(serial_irq_n, expIrq(cfg, r[6:4]));
      chk(ctrlDsr_b, r[8]);
    end
    // connector clocks inside a frame, config set beforehand
    wr(CFG_ADDR, 16'h0678);
    @(posedge clk);
    lineIsClk <= 1'b1;
    frameOn <= 1'b1;
    cyc(8);
    repeat (200) begin
      cyc(1);
      chk(ctrlTxClk, hist[5]);
      chk(ctrlRxClk, hist[4]);
      chk(rxClkPin, hist[4]);
      chk(ctrlDsr_b, 1'b1);
    end
    @(posedge clk);
    frameOn <= 1'b0;
    lineIsClk <= 1'b0;
    // connector clock activity is sticky until written clear
    rd(STAT_ADDR, rdv);
    chk(rdv & 16'h0004, 16'h0004);
    // external transmit clock without the line set as clock
    wr(CFG_ADDR, 16'h0218);
    wr(STAT_ADDR, 16'h0004);
    rd(STAT_ADDR, rdv);
    chk(rdv & 16'h0004, 16'h0000);
    halfp(hp);
    halfp(hp);
    chk(16'(hp), 16'(expHalf(0, 4)));
    // clock enable low freezes the generator and drops a write
    hold = ctrlTxClk;
    @(posedge clk);
    ce <= 1'b0;
    wr(CFG_ADDR, 16'h0200);
    cyc(300);
    chk(ctrlTxClk, hold);
    @(posedge clk);
    ce <= 1'b1;
    rd(CFG_ADDR, rdv);
    chk(rdv, 16'h0218);
    complete_run;
  end
endmodule

/* File: tb/serial_line_model.sv */
//
// Purpose: connector-side line equipment for the serial clock routing bench
// Assumes: frame and line mode are set by the bench between frames
// Notes:   link clock is 800 ns and stands still outside frames
//
`timescale 1ns/10ps
module serial_line_model (
  // frame control
  input wire logic frameOn,
  input wire logic lineIsClk,
  input wire logic dtr_b,
  // connector lines
  output logic sharedLine,
  output logic terminal_tx_clock
);
  logic linkClk;

  // odd start offset keeps link edges off the block clock edges
  initial begin
    linkClk = 1'b0;
    #37;
    forever begin
      #400;
      if (frameOn) begin
        linkClk = ~linkClk;
      end
    end
  end

  // shared line carries terminal-ready or clock, never both
  assign sharedLine = lineIsClk ? linkClk : dtr_b;
  assign terminal_tx_clock = linkClk;
endmodule
